// ===== pkg/deser_pkg.sv
package deser_pkg;
   // ****************************************
   // widths and mode codes
   // ****************************************
   localparam int          WORD_W     = 22;
   localparam int          FIFO_DEPTH = 8;
   localparam logic [1:0]  MODE_PDN   = 2'h0;
   localparam logic [1:0]  MODE_THREE = 2'h3;
   localparam logic        START_BIT  = 1'h1;
   localparam logic        DIR_DESER  = 1'h0;

   // ****************************************
   // timing: partner reference period and local clock
   // ****************************************
   localparam int CLK_PERIOD_NS = 10;
   localparam int REF_PERIOD_NS = 100;
   // low time of the word clock, rounded up, never under one cycle
   localparam int LOW_HALF_CYC_RAW = ((REF_PERIOD_NS / 2) + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LOW_FULL_CYC_RAW = (REF_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LOW_HALF_CYC     = (LOW_HALF_CYC_RAW < 1) ? 1 : LOW_HALF_CYC_RAW;
   localparam int LOW_FULL_CYC     = (LOW_FULL_CYC_RAW < 1) ? 1 : LOW_FULL_CYC_RAW;
   localparam int LOW_CNT_W        = 8;
endpackage

// ===== verilog/deserializer_word_clock_output.sv
`timescale 1ns/1ps

// ****************************************
// word fifo, same clock on both sides
// ****************************************
module word_fifo #(
   parameter int WIDTH = 22,
   parameter int DEPTH = 8
) (
   input  wire logic             clk,
   input  wire logic             clr,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wp_r;
   logic [AW:0]      wp_nxt;
   logic [AW:0]      rp_r;
   logic [AW:0]      rp_nxt;
   logic             push;
   logic             pop;

   // full when pointers differ only in the wrap bit
   assign in_ready  = !((wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]));
   assign out_valid = (wp_r != rp_r);
   assign out_data  = mem[rp_r[AW-1:0]];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // pointer advance
   always_comb begin
      wp_nxt = push ? wp_r + (AW+1)'(1) : wp_r;
      rp_nxt = pop ? rp_r + (AW+1)'(1) : rp_r;
      if (clr) begin
         wp_nxt = '0;
         rp_nxt = '0;
      end
   end

   // storage has no reset; only the pointers say what is valid
   always_ff @(posedge clk) begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      if (push) begin
         mem[wp_r[AW-1:0]] <= in_data;
      end
   end
endmodule // word_fifo

// Function
// - same receive logic for any reference ratio
// - idle bits between words are skipped
// - one word clock period per word
// - modes 1,2: low half reference period
// - mode 3: low one reference period
// - word clock high for rest of period
// - parallel inputs gated off when deserializing
// - outputs driven when deserializing and mode active
// - data pins high impedance otherwise; word clock floats only in power-down and while reset_n is low
// - data outputs start at zero on power-up, word clock high
// - direction low selects deserializer
// - both mode bits low: power-down and reset
// - serializer: receiver off, word clock high
// - words recovered on received bit clock
module deserializer_word_clock_output
   import deser_pkg::*;
#(
   parameter int WORD_BITS = deser_pkg::WORD_W,
   parameter int DEPTH     = deser_pkg::FIFO_DEPTH,
   parameter int LOW_HALF  = deser_pkg::LOW_HALF_CYC,
   parameter int LOW_FULL  = deser_pkg::LOW_FULL_CYC
) (
   input  wire logic                 clk,
   input  wire logic                 reset_n,
   input  wire logic                 serial_bit_clock_in,
   input  wire logic                 serial_data_in,
   input  wire logic                 direction_select_in,
   input  wire logic                 mode_select_low_bit,
   input  wire logic                 mode_select_high_bit,
   input  wire logic [WORD_BITS-1:0] data_pin_i,
   output logic [WORD_BITS-1:0]      data_pin_o,
   output logic                      data_pin_oe,
   output logic [WORD_BITS-1:0]      serializer_data,
   output logic                      parallel_word_clock,
   output logic                      word_clock_oe
);
   import deser_pkg::*;

   typedef enum logic [0:0] {LK_HUNT, LK_DATA} link_state_e;
   typedef enum logic [0:0] {WC_HIGH, WC_LOW} wclk_state_e;

   // ****************************************
   // pin synchronisers, local clock
   // ****************************************
   logic [2:0] pin_s1_r;
   logic [2:0] pin_s2_r;
   logic       dir_s;
   logic [1:0] mode_s;
   logic       deser_run;

   // first stage feeds only the second stage
   always_ff @(posedge clk) begin
      pin_s1_r <= {direction_select_in, mode_select_high_bit, mode_select_low_bit};
      pin_s2_r <= pin_s1_r;
   end

   assign dir_s  = pin_s2_r[2];
   assign mode_s = pin_s2_r[1:0];
   // receive path runs only in an active mode with direction low
   assign deser_run = reset_n && (mode_s != MODE_PDN) && (dir_s == DIR_DESER);

   // ****************************************
   // link domain: serial bit clock
   // ****************************************
   logic                 lk_run_s1_r;
   logic                 lk_run_s2_r;
   logic                 ack_s1_r;
   logic                 ack_s2_r;
   link_state_e          lk_st_r;
   link_state_e          lk_st_nxt;
   logic [WORD_BITS-1:0] sh_r;
   logic [WORD_BITS-1:0] sh_nxt;
   logic [4:0]           bit_r;
   logic [4:0]           bit_nxt;
   logic [WORD_BITS-1:0] hold_r;
   logic [WORD_BITS-1:0] hold_nxt;
   logic                 req_tog_r;
   logic                 req_tog_nxt;
   logic                 ack_tog_r;

   // run level and ack toggle cross into the link domain
   always_ff @(posedge serial_bit_clock_in) begin
      lk_run_s1_r <= deser_run;
      lk_run_s2_r <= lk_run_s1_r;
      ack_s1_r    <= ack_tog_r;
      ack_s2_r    <= ack_s1_r;
   end

   // frame: idle zeros, a start one, then the word lsb first
   always_comb begin
      lk_st_nxt   = lk_st_r;
      sh_nxt      = sh_r;
      bit_nxt     = bit_r;
      hold_nxt    = hold_r;
      req_tog_nxt = req_tog_r;
      unique case (lk_st_r)
         LK_HUNT: begin
            // filler bits between words never reach the word path
            if (serial_data_in == START_BIT) begin
               lk_st_nxt = LK_DATA;
               bit_nxt   = '0;
            end
         end
         LK_DATA: begin
            sh_nxt  = {serial_data_in, sh_r[WORD_BITS-1:1]};
            bit_nxt = bit_r + 5'h01;
            if (bit_r == 5'(WORD_BITS - 1)) begin
               lk_st_nxt = LK_HUNT;
               // hold is only rewritten once the last word was taken
               if (req_tog_r == ack_s2_r) begin
                  hold_nxt    = {serial_data_in, sh_r[WORD_BITS-1:1]};
                  req_tog_nxt = !req_tog_r;
               end
            end
         end
      endcase
      if (!lk_run_s2_r) begin
         lk_st_nxt   = LK_HUNT;
         bit_nxt     = '0;
         // copy the ack while stopped, so both toggles start out paired
         req_tog_nxt = ack_s2_r;
      end
   end

   // link registers; a reset needs a few bit clocks here, or a stale toggle looks like a word
   always_ff @(posedge serial_bit_clock_in) begin
      lk_st_r   <= lk_st_nxt;
      sh_r      <= sh_nxt;
      bit_r     <= bit_nxt;
      hold_r    <= hold_nxt;
      req_tog_r <= req_tog_nxt;
   end

   // ****************************************
   // word hand-over into the local clock
   // ****************************************
   logic                 req_s1_r;
   logic                 req_s2_r;
   logic                 ack_tog_nxt;
   logic                 fifo_in_ready;
   logic                 fifo_in_valid;
   logic                 fifo_out_valid;
   logic                 fifo_out_ready;
   logic [WORD_BITS-1:0] fifo_out_data;

   // a new word is pending while the toggles differ
   assign fifo_in_valid = (req_s2_r != ack_tog_r);
   always_comb begin
      ack_tog_nxt = ack_tog_r;
      if (fifo_in_valid && fifo_in_ready) begin
         ack_tog_nxt = req_s2_r;
      end
      // while stopped, a pending word is dropped but the toggles stay paired
      if (!deser_run) begin
         ack_tog_nxt = req_s2_r;
      end
      // reset gives the pair a known start; the link copies it on its next edges
      if (!reset_n) begin
         ack_tog_nxt = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      req_s1_r  <= req_tog_r;
      req_s2_r  <= req_s1_r;
      ack_tog_r <= ack_tog_nxt;
   end

   // hold_r stays still until acknowledged, so the bus is safe to sample
   word_fifo #(
      .WIDTH (WORD_BITS),
      .DEPTH (DEPTH)
   ) u_fifo (
      .clk       (clk),
      .clr       (!deser_run),
      .in_valid  (fifo_in_valid),
      .in_ready  (fifo_in_ready),
      .in_data   (hold_r),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready),
      .out_data  (fifo_out_data)
   );

   // ****************************************
   // word clock generator
   // ****************************************
   wclk_state_e          wc_st_r;
   wclk_state_e          wc_st_nxt;
   logic [LOW_CNT_W-1:0] low_cnt_r;
   logic [LOW_CNT_W-1:0] low_cnt_nxt;
   logic [LOW_CNT_W-1:0] low_len;
   logic [WORD_BITS-1:0] dout_r;
   logic [WORD_BITS-1:0] dout_nxt;
   logic                 wck_r;
   logic                 wck_nxt;

   // low time follows the mode; high time is whatever is left until the next word
   assign low_len = (mode_s == MODE_THREE) ? LOW_CNT_W'(LOW_FULL)
                                           : LOW_CNT_W'(LOW_HALF);
   // pop only from the high phase, which stalls the fifo otherwise
   assign fifo_out_ready = (wc_st_r == WC_HIGH) && deser_run;

   always_comb begin
      wc_st_nxt   = wc_st_r;
      low_cnt_nxt = low_cnt_r;
      dout_nxt    = dout_r;
      wck_nxt     = wck_r;
      unique case (wc_st_r)
         WC_HIGH: begin
            // one low pulse per received word, so rate equals strobe rate
            if (fifo_out_valid && fifo_out_ready) begin
               wc_st_nxt   = WC_LOW;
               low_cnt_nxt = low_len - LOW_CNT_W'(1);
               dout_nxt    = fifo_out_data;
               wck_nxt     = 1'b0;
            end
         end
         WC_LOW: begin
            if (low_cnt_r == '0) begin
               wc_st_nxt = WC_HIGH;
               wck_nxt   = 1'b1;
            end else begin
               low_cnt_nxt = low_cnt_r - LOW_CNT_W'(1);
            end
         end
      endcase
      if (!deser_run) begin
         wc_st_nxt   = WC_HIGH;
         low_cnt_nxt = '0;
         wck_nxt     = 1'b1;
         // power-down clears the word; serializer keeps the last one
         if (!reset_n || mode_s == MODE_PDN) begin
            dout_nxt = '0;
         end
      end
   end

   always_ff @(posedge clk) begin
      wc_st_r   <= wc_st_nxt;
      low_cnt_r <= low_cnt_nxt;
      dout_r    <= dout_nxt;
      wck_r     <= wck_nxt;
   end

   // ****************************************
   // parallel pins
   // ****************************************
   assign data_pin_o          = dout_r;
   assign data_pin_oe         = deser_run;
   assign parallel_word_clock = wck_r;
   // word clock floats only in power-down and while reset_n is low
   assign word_clock_oe       = reset_n && (mode_s != MODE_PDN);
   logic [WORD_BITS-1:0] din_s1_r;
   logic [WORD_BITS-1:0] din_s2_r;
   logic [WORD_BITS-1:0] ser_data_r;
   logic [WORD_BITS-1:0] ser_data_nxt;

   // input buffers pass data only when serializing
   always_comb begin
      ser_data_nxt = '0;
      if (reset_n && dir_s != DIR_DESER && mode_s != MODE_PDN) begin
         ser_data_nxt = din_s2_r;
      end
   end

   // pads synced bit by bit: a word changing mid-sample may look mixed for one cycle
   always_ff @(posedge clk) begin
      din_s1_r   <= data_pin_i;
      din_s2_r   <= din_s1_r;
      ser_data_r <= ser_data_nxt;
   end

   assign serializer_data = ser_data_r;
endmodule // deserializer_word_clock_output

// ===== verification/ser_model.sv
`timescale 1ns/1ps

// ******
// serializer partner: bit clock runs only while sending idle bits and frames
// ******
module ser_model (
   output logic sclk,
   output logic sdata
);
   initial begin
      sclk  = 1'h0;
      sdata = 1'h0;
   end

   // data set while the clock is low, taken on its rise
   task bit_out(input logic b);
      sdata = b;
      #3 sclk = 1'h1;
      #3 sclk = 1'h0;
   endtask

   // idle zeros between words, then start bit and word lsb first
   task send(input logic [21:0] w, input int idle, input logic go);
      for (int i = 0; i < idle; i++) bit_out(1'h0);
      if (go) begin
         bit_out(1'h1);
         for (int i = 0; i < 22; i++) bit_out(w[i]);
      end
      // a released line must not keep showing its last level
      sdata = ~sdata;
   endtask
endmodule // ser_model

// ===== verification/deser_chk_sva.sv
`timescale 1ns/1ps

module deser_chk #(
   parameter int WORD_BITS = 22,
   parameter int LOW_HALF  = 5,
   parameter int LOW_FULL  = 10
) (
   input wire logic                 clk,
   input wire logic                 reset_n,
   input wire logic                 direction_select_in,
   input wire logic                 mode_select_low_bit,
   input wire logic                 mode_select_high_bit,
   input wire logic [WORD_BITS-1:0] data_pin_o,
   input wire logic                 data_pin_oe,
   input wire logic [WORD_BITS-1:0] serializer_data,
   input wire logic                 parallel_word_clock,
   input wire logic                 word_clock_oe
);
   logic [7:0] low_cnt_r, low_cnt_nxt;
   logic       full_r, full_nxt;
   logic       act;
   assign act = mode_select_low_bit | mode_select_high_bit;

   // low cycles counted; mode latched only while the clock is high
   always_comb begin
      low_cnt_nxt = parallel_word_clock ? 8'h00 : low_cnt_r + 8'h01;
      full_nxt    = parallel_word_clock ? (mode_select_low_bit & mode_select_high_bit) : full_r;
   end
   always_ff @(posedge clk) begin
      low_cnt_r <= low_cnt_nxt;
      full_r    <= full_nxt;
   end

   default clocking @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   low_time_a: assert property ($rose(parallel_word_clock) && word_clock_oe |->
      int'(low_cnt_r) == (full_r ? LOW_FULL : LOW_HALF)) else $error("word clock low time wrong");
   pd_off_a: assert property ((!act)[*3] |=> !data_pin_oe && !word_clock_oe)
      else $error("outputs driven in power-down");
   pd_clear_a: assert property ((!act)[*4] |=> data_pin_o == '0)
      else $error("word not cleared in power-down");
   ser_high_a: assert property (direction_select_in[*3] |=> parallel_word_clock && !data_pin_oe)
      else $error("serializer word clock not high");
   in_gate_a: assert property ((!direction_select_in)[*3] |=> serializer_data == '0)
      else $error("inputs not gated");
   oe_on_a: assert property ((!direction_select_in && act)[*3] |=> data_pin_oe && word_clock_oe)
      else $error("outputs not driven");
   hold_high_a: assert property (parallel_word_clock && $past(parallel_word_clock) && word_clock_oe
      && $past(word_clock_oe) |-> $stable(data_pin_o)) else $error("data moved while clock high");
   start_zero_a: assert property ($past(reset_n) == 1'b0 |-> data_pin_o == '0)
      else $error("outputs not zero at start");
endmodule // deser_chk

bind deserializer_word_clock_output deser_chk #(.WORD_BITS(WORD_BITS), .LOW_HALF(LOW_HALF), .LOW_FULL(LOW_FULL)) chk (
   .clk(clk), .reset_n(reset_n), .direction_select_in(direction_select_in),
   .mode_select_low_bit(mode_select_low_bit), .mode_select_high_bit(mode_select_high_bit),
   .data_pin_o(data_pin_o), .data_pin_oe(data_pin_oe), .serializer_data(serializer_data),
   .parallel_word_clock(parallel_word_clock), .word_clock_oe(word_clock_oe));

// ===== verification/tb_top.sv
`timescale 1ns/1ps

module tb_top;
   import deser_pkg::*;
   localparam int LH = 2;
   localparam int LF = 4;
   logic        clk = 1'h0;
   logic        reset_n = 1'h0;
   logic        dir = 1'h0;
   logic        lo = 1'h1;
   logic        hi = 1'h0;
   logic [21:0] din = 22'h0;
   logic [21:0] w, dout, sdat;
   logic        sclk, sdata, doe, pwc, woe;
   logic        pwc_d = 1'h1;
   logic [15:0] lf = 16'h0EC1;
   logic [21:0] exp_q[$];
   int          err_count = 0;
   int          n_checks = 0;

   always #5 clk = ~clk;

   ser_model ser (.sclk(sclk), .sdata(sdata));
   deserializer_word_clock_output #(.LOW_HALF(LH), .LOW_FULL(LF)) DUT (
      .clk(clk), .reset_n(reset_n), .serial_bit_clock_in(sclk), .serial_data_in(sdata),
      .direction_select_in(dir), .mode_select_low_bit(lo), .mode_select_high_bit(hi),
      .data_pin_i(din), .data_pin_o(dout), .data_pin_oe(doe), .serializer_data(sdat),
      .parallel_word_clock(pwc), .word_clock_oe(woe));

   // ******
   // helpers
   // ******
   task rnd(output logic [21:0] r);
      for (int i = 0; i < 22; i++) begin
         lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
         r[i] = lf[0];
      end
   endtask
   task check(input logic [21:0] seen, input logic [21:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task conclude();
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task clks(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task drain();
      for (int t = 0; t < 200 && exp_q.size() != 0; t++) @(posedge clk);
      clks(LF + 4);
   endtask
   task word();
      rnd(w);
      exp_q.push_back(w);
      ser.send(w, 4, 1'h1);
      clks(5);
   endtask

   // ******
   // monitor: each falling word clock presents the oldest word
   // ******
   always @(posedge clk) begin
      #2;
      if (pwc_d === 1'h1 && pwc === 1'h0) begin
         if (exp_q.size() == 0) check(22'h0, 22'h3FFFFF);
         else check(dout, exp_q.pop_front());
      end
      pwc_d = pwc;
   end

   initial begin
      #100000;
      err_count++;
      conclude();
   end

   // ******
   // main sequence
   // ******
   initial begin
      // bit clocks during reset let the link side clear as well
      fork
         ser.send(22'h0, 6, 1'h0);
         clks(5);
      join
      check(dout, 22'h0);
      check({21'h0, doe}, 22'h0);
      check({21'h0, pwc}, 22'h1);
      reset_n = 1'h1;
      clks(10);
      for (int m = 1; m < 4; m++) begin
         {hi, lo} = m[1:0];
         clks(6);
         for (int k = 0; k < 3; k++) word();
         drain();
      end
      {hi, lo} = 2'h0;
      clks(6);
      check({20'h0, doe, woe}, 22'h0);
      check(dout, 22'h0);
      {hi, lo} = 2'h3;
      dir = 1'h1;
      rnd(din);
      clks(6);
      check({20'h0, pwc, doe}, 22'h2);
      check(sdat, din);
      dir = 1'h0;
      clks(6);
      check(sdat, 22'h0);
      check({21'h0, doe}, 22'h1);
      ser.send(22'h0, 4, 1'h0);
      word();
      drain();
      conclude();
   end
endmodule // tb_top
